// file: rtl/lcc_config_regs.sv
// Lane conditioning configuration register bank
`timescale 1ns/1ps
module lcc_config_regs
   import lcc_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst_b,
   input  wire logic                 clk_en,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   output logic                      reg_hit,
   output lcc_out_ctl_t [N_OUT-1:0]  out_ctl,
   output lcc_in_ctl_t  [N_IN-1:0]   in_ctl
);
   // ==================================================
   // Storage
   logic [7:0] p1_idle_rate_r, p1_inb_eq_r, p1_swing_r, p1_deemph_r;
   logic [7:0] p1_inb_thr_r;
   logic [7:0] p0a_idle_rate_r, p0_in_eq_r, p0a_swing_r, p0a_deemph_r;
   logic [7:0] p0_in_thr_r, p0b_idle_rate_r, p0b_swing_r;
   logic [7:0] rdata_nxt;
   logic       hit_nxt;
   logic       wr_go;
   lcc_out_ctl_t [N_OUT-1:0] out_nxt;
   lcc_in_ctl_t  [N_IN-1:0]  in_nxt;

   assign wr_go = clk_en && reg_wr;

   // ==================================================
   // Register writes; values kept whole as written
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         p1_idle_rate_r  <= RST_IDLE_RATE;
         p1_inb_eq_r     <= RST_EQ;
         p1_swing_r      <= RST_SWING;
         p1_deemph_r     <= RST_DEEMPH;
         p1_inb_thr_r    <= RST_IDLE_THR;
         p0a_idle_rate_r <= RST_IDLE_RATE;
         p0_in_eq_r      <= RST_EQ;
         p0a_swing_r     <= RST_SWING;
         p0a_deemph_r    <= RST_DEEMPH;
         p0_in_thr_r     <= RST_IDLE_THR;
         p0b_idle_rate_r <= RST_IDLE_RATE;
         p0b_swing_r     <= RST_SWING;
      end else if (wr_go) begin
         unique case (reg_addr)
            OFS_P1_OUT_IDLE_RATE:  p1_idle_rate_r  <= reg_wdata;
            OFS_P1_INB_EQ:         p1_inb_eq_r     <= reg_wdata;
            OFS_P1_OUT_SWING:      p1_swing_r      <= reg_wdata;
            OFS_P1_OUT_DEEMPH:     p1_deemph_r     <= reg_wdata;
            OFS_P1_INB_IDLE_THR:   p1_inb_thr_r    <= reg_wdata;
            OFS_P0_OUTA_IDLE_RATE: p0a_idle_rate_r <= reg_wdata;
            OFS_P0_IN_EQ:          p0_in_eq_r      <= reg_wdata;
            OFS_P0_OUTA_SWING:     p0a_swing_r     <= reg_wdata;
            OFS_P0_OUTA_DEEMPH:    p0a_deemph_r    <= reg_wdata;
            OFS_P0_IN_IDLE_THR:    p0_in_thr_r     <= reg_wdata;
            OFS_P0_OUTB_IDLE_RATE: p0b_idle_rate_r <= reg_wdata;
            OFS_P0_OUTB_SWING:     p0b_swing_r     <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ==================================================
   // Read mux; unmapped offsets read zero with no hit
   always_comb begin
      hit_nxt = 1'b1;
      unique case (reg_addr)
         OFS_P1_OUT_IDLE_RATE:  rdata_nxt = p1_idle_rate_r;
         OFS_P1_INB_EQ:         rdata_nxt = p1_inb_eq_r;
         OFS_P1_OUT_SWING:      rdata_nxt = p1_swing_r;
         OFS_P1_OUT_DEEMPH:     rdata_nxt = p1_deemph_r;
         OFS_P1_INB_IDLE_THR:   rdata_nxt = p1_inb_thr_r;
         OFS_P0_OUTA_IDLE_RATE: rdata_nxt = p0a_idle_rate_r;
         OFS_P0_IN_EQ:          rdata_nxt = p0_in_eq_r;
         OFS_P0_OUTA_SWING:     rdata_nxt = p0a_swing_r;
         OFS_P0_OUTA_DEEMPH:    rdata_nxt = p0a_deemph_r;
         OFS_P0_IN_IDLE_THR:    rdata_nxt = p0_in_thr_r;
         OFS_P0_OUTB_IDLE_RATE: rdata_nxt = p0b_idle_rate_r;
         OFS_P0_OUTB_SWING:     rdata_nxt = p0b_swing_r;
         default: begin
            rdata_nxt = 8'h00;
            hit_nxt   = 1'b0;
         end
      endcase
   end

   // Registered read answer, one cycle after the read strobe
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
         reg_hit   <= 1'b0;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= rdata_nxt;
         reg_hit   <= hit_nxt;
      end
   end

   // ==================================================
   // Lane decoders; output B of lane 0 has no de-emphasis register
   // here, so it decodes its own reset value
   lcc_out_decode u_out_p1 (
      .idle_rate (p1_idle_rate_r),
      .swing     (p1_swing_r),
      .deemph    (p1_deemph_r),
      .ctl       (out_nxt[0])
   );
   lcc_out_decode u_out_p0a (
      .idle_rate (p0a_idle_rate_r),
      .swing     (p0a_swing_r),
      .deemph    (p0a_deemph_r),
      .ctl       (out_nxt[1])
   );
   lcc_out_decode u_out_p0b (
      .idle_rate (p0b_idle_rate_r),
      .swing     (p0b_swing_r),
      .deemph    (RST_DEEMPH),
      .ctl       (out_nxt[2])
   );
   lcc_in_decode u_in_p1b (
      .eq  (p1_inb_eq_r),
      .thr (p1_inb_thr_r),
      .ctl (in_nxt[0])
   );
   lcc_in_decode u_in_p0 (
      .eq  (p0_in_eq_r),
      .thr (p0_in_thr_r),
      .ctl (in_nxt[1])
   );

   // ==================================================
   // Static controls to the analog lanes, registered
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_ctl <= '0;
         in_ctl  <= '0;
      end else if (clk_en) begin
         out_ctl <= out_nxt;
         in_ctl  <= in_nxt;
      end
   end
endmodule

// file: rtl/lcc_pkg.sv
// Package: register map, field layout, reset values and decode types
package lcc_pkg;
   // ==================================================
   // Register offsets
   localparam logic [7:0] OFS_P1_OUT_IDLE_RATE = 8'h23;
   localparam logic [7:0] OFS_P1_INB_EQ        = 8'h24;
   localparam logic [7:0] OFS_P1_OUT_SWING     = 8'h25;
   localparam logic [7:0] OFS_P1_OUT_DEEMPH    = 8'h26;
   localparam logic [7:0] OFS_P1_INB_IDLE_THR  = 8'h27;
   localparam logic [7:0] OFS_P0_OUTA_IDLE_RATE = 8'h2B;
   localparam logic [7:0] OFS_P0_IN_EQ         = 8'h2C;
   localparam logic [7:0] OFS_P0_OUTA_SWING    = 8'h2D;
   localparam logic [7:0] OFS_P0_OUTA_DEEMPH   = 8'h2E;
   localparam logic [7:0] OFS_P0_IN_IDLE_THR   = 8'h2F;
   localparam logic [7:0] OFS_P0_OUTB_IDLE_RATE = 8'h32;
   localparam logic [7:0] OFS_P0_OUTB_SWING    = 8'h34;
   // ==================================================
   // Reset values
   localparam logic [7:0] RST_IDLE_RATE = 8'h00;
   localparam logic [7:0] RST_EQ        = 8'h20;
   localparam logic [7:0] RST_SWING     = 8'h03;
   localparam logic [7:0] RST_DEEMPH    = 8'h03;
   localparam logic [7:0] RST_IDLE_THR  = 8'h00;
   // ==================================================
   // Field positions
   localparam int IR_IDLE_AUTO = 5;
   localparam int IR_IDLE_SEL  = 4;
   localparam int IR_RATE_AUTO = 1;
   localparam int IR_RATE_SEL  = 0;
   localparam int EQ_EN        = 5;
   localparam int EQ_GST_HI    = 4;
   localparam int EQ_GST_LO    = 3;
   localparam int EQ_BST_HI    = 2;
   localparam int DE_TYPE      = 7;
   localparam int THR_DEA_HI   = 3;
   localparam int THR_DEA_LO   = 2;
   localparam int THR_AS_HI    = 1;
   // ==================================================
   // Documented codes
   localparam logic [5:0] EQ_BYPASS = 6'h20;
   localparam logic [6:0] SW_L0 = 7'h03;
   localparam logic [6:0] SW_L1 = 7'h07;
   localparam logic [6:0] SW_L2 = 7'h0F;
   localparam logic [6:0] SW_L3 = 7'h1F;
   localparam logic [7:0] DE_C0 = 8'h01;
   localparam logic [7:0] DE_C1 = 8'hE8;
   localparam logic [7:0] DE_C2 = 8'h88;
   localparam logic [7:0] DE_C3 = 8'h90;
   localparam logic [7:0] DE_C4 = 8'hA0;
   localparam int N_OUT = 3;
   localparam int N_IN  = 2;

   // Data-rate bands
   typedef enum logic {LCC_RATE_LOW, LCC_RATE_HIGH} lcc_rate_t;

   // Controls of one output lane
   typedef struct packed {
      logic       idle_auto;    // Automatic electrical idle detect
      logic       mute;         // Manual mute to electrical idle
      logic       sig_det_en;   // Signal detect active
      logic       rate_auto;    // Automatic data-rate detect
      lcc_rate_t  rate;         // Manual rate band
      logic [2:0] swing_lvl;    // 0..3 swing, 7 = undefined code
      logic       de_type;      // 0 compatibility, 1 enhanced
      logic [6:0] de_level;     // Raw level control
      logic [2:0] de_step;      // 0..4 strength, 7 = undocumented
   } lcc_out_ctl_t;

   // Controls of one input lane
   typedef struct packed {
      logic       eq_en;
      logic [1:0] gain_stage_sel;
      logic [2:0] boost_level_sel;
      logic [3:0] eq_step;      // 0 bypass, 1..8 boost, 15 other
      logic [1:0] thr_deassert;
      logic [1:0] thr_assert;
   } lcc_in_ctl_t;
endpackage

// file: rtl/lcc_out_decode.sv
// One output lane: idle/rate, swing and de-emphasis decode
`timescale 1ns/1ps
module lcc_out_decode
   import lcc_pkg::*;
(
   input  wire logic [7:0]   idle_rate,
   input  wire logic [7:0]   swing,
   input  wire logic [7:0]   deemph,
   output lcc_out_ctl_t      ctl
);
   // Combine fields into lane controls
   always_comb begin
      ctl           = '0;
      ctl.idle_auto = idle_rate[IR_IDLE_AUTO];
      // Manual bit only matters when automatic idle is off
      ctl.mute      = !idle_rate[IR_IDLE_AUTO] &&
                      idle_rate[IR_IDLE_SEL];
      ctl.sig_det_en = idle_rate[IR_IDLE_AUTO];
      ctl.rate_auto = idle_rate[IR_RATE_AUTO];
      ctl.rate      = idle_rate[IR_RATE_SEL] ? LCC_RATE_HIGH
                                             : LCC_RATE_LOW;
      ctl.de_type   = deemph[DE_TYPE];
      ctl.de_level  = deemph[6:0];
      unique case (swing[6:0])
         SW_L0:   ctl.swing_lvl = 3'd0;
         SW_L1:   ctl.swing_lvl = 3'd1;
         SW_L2:   ctl.swing_lvl = 3'd2;
         SW_L3:   ctl.swing_lvl = 3'd3;
         default: ctl.swing_lvl = 3'd7;
      endcase
      unique case (deemph)
         DE_C0:   ctl.de_step = 3'd0;
         DE_C1:   ctl.de_step = 3'd1;
         DE_C2:   ctl.de_step = 3'd2;
         DE_C3:   ctl.de_step = 3'd3;
         DE_C4:   ctl.de_step = 3'd4;
         default: ctl.de_step = 3'd7;
      endcase
   end
endmodule

// file: rtl/lcc_in_decode.sv
// One input lane: equalizer and idle threshold decode
`timescale 1ns/1ps
module lcc_in_decode
   import lcc_pkg::*;
(
   input  wire logic [7:0]   eq,
   input  wire logic [7:0]   thr,
   output lcc_in_ctl_t       ctl
);
   // Split fields and rank documented boost codes
   always_comb begin
      ctl                 = '0;
      ctl.eq_en           = eq[EQ_EN];
      ctl.gain_stage_sel  = eq[EQ_GST_HI:EQ_GST_LO];
      ctl.boost_level_sel = eq[EQ_BST_HI:0];
      ctl.thr_deassert    = thr[THR_DEA_HI:THR_DEA_LO];
      ctl.thr_assert      = thr[THR_AS_HI:0];
      unique case (eq[5:0])
         EQ_BYPASS: ctl.eq_step = 4'h0;
         6'h2A:     ctl.eq_step = 4'h1;
         6'h30:     ctl.eq_step = 4'h2;
         6'h32:     ctl.eq_step = 4'h3;
         6'h39:     ctl.eq_step = 4'h4;
         6'h35:     ctl.eq_step = 4'h5;
         6'h37:     ctl.eq_step = 4'h6;
         6'h3B:     ctl.eq_step = 4'h7;
         6'h3D:     ctl.eq_step = 4'h8;
         default:   ctl.eq_step = 4'hF;
      endcase
   end
endmodule

// file: testbench/lcc_config_regs_asserts.sv
// Assertion checker for the lane conditioning register bank
`timescale 1ns/1ps
module lcc_config_regs_chk
   import lcc_pkg::*;
(
   input wire logic                     sys_clk,
   input wire logic                     rst_b,
   input wire logic                     clk_en,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   input wire logic [7:0]               reg_addr,
   input wire logic [7:0]               reg_wdata,
   input wire logic [7:0]               reg_rdata,
   input wire logic                     reg_hit,
   input wire lcc_out_ctl_t [N_OUT-1:0] out_ctl,
   input wire lcc_in_ctl_t [N_IN-1:0]   in_ctl
);
   // ==================================================
   // Helpers
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire logic wr = clk_en & reg_wr;
   logic [7:0] wd1_r;
   logic [7:0] wd2_r;
   // Write data delayed to line up with the decoded controls
   always_ff @(posedge sys_clk) begin
      wd1_r <= reg_wdata;
      wd2_r <= wd1_r;
   end
   sequence s_wr(logic [7:0] a);
      wr && reg_addr == a ##1 clk_en;
   endsequence
   // ==================================================
   // Assertions
   chk_idle_auto_sel: assert property (s_wr(8'h23) |=>
      {out_ctl[0].idle_auto, out_ctl[0].sig_det_en} == {2{wd2_r[5]}})
      else $error("auto idle bit not applied");
   chk_manual_mute: assert property (s_wr(8'h2B) |=>
      out_ctl[1].mute == (!wd2_r[5] && wd2_r[4]))
      else $error("manual mute wrong");
   chk_rate_sel: assert property (s_wr(8'h32) |=>
      {out_ctl[2].rate_auto, out_ctl[2].rate} == wd2_r[1:0])
      else $error("rate controls wrong");
   chk_eq_bypass: assert property ($past(rst_b) &&
      in_ctl[0].eq_step == 4'h0 |-> in_ctl[0][13:8] == 6'h20)
      else $error("bypass step from other code");
   chk_swing_top: assert property (wr && reg_addr == 8'h25 &&
      reg_wdata == 8'h1F ##1 clk_en |=> out_ctl[0].swing_lvl == 3'h3)
      else $error("largest swing not selected");
   chk_deemph_fields: assert property (s_wr(8'h2E) |=>
      {out_ctl[1].de_type, out_ctl[1].de_level} == wd2_r)
      else $error("de-emphasis fields wrong");
   chk_deemph_max: assert property ($past(rst_b) &&
      out_ctl[1].de_step == 3'h4 |-> out_ctl[1].de_level == 7'h20)
      else $error("strongest step from other code");
   chk_thr_fields: assert property (s_wr(8'h2F) |=>
      {in_ctl[1].thr_deassert, in_ctl[1].thr_assert} == wd2_r[3:0])
      else $error("threshold fields wrong");
   chk_unmapped_read: assert property (clk_en && reg_rd &&
      !(reg_addr inside {[8'h23:8'h27], [8'h2B:8'h2F], 8'h32, 8'h34})
      |=> !reg_hit && reg_rdata == 8'h00)
      else $error("unmapped read not refused");
   // Main scenarios
   cov_idle_write: cover property (s_wr(8'h23));
   cov_deemph_max: cover property (out_ctl[1].de_step == 3'h4);
   cov_read_hit: cover property (clk_en && reg_rd ##1 reg_hit);
endmodule
bind lcc_config_regs lcc_config_regs_chk u_chk (.sys_clk, .rst_b,
   .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
   .reg_hit, .out_ctl, .in_ctl);

// file: testbench/lcc_host_model.sv
// Host model that issues register writes and reads
`timescale 1ns/1ps
module lcc_host_model
   import lcc_pkg::*;
(
   input  wire logic       sys_clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_hit
);
   // Bus idle at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Bits the host may set; reserved ones are sent as zero
   function automatic logic [7:0] keep(input logic [7:0] a);
      case (a)
         8'h23, 8'h2B, 8'h32: keep = 8'h33;
         8'h24, 8'h2C: keep = 8'h3F;
         8'h25, 8'h2D, 8'h34: keep = 8'h7F;
         8'h27, 8'h2F: keep = 8'h0F;
         default: keep = 8'hFF;
      endcase
   endfunction
   // One write strobe; the reserved swing code is never sent
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (keep(a) == 8'h7F && d[6:0] == 7'h3F) return;
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d & keep(a);
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
   endtask
   // One read strobe; the answer stands from the taking edge on
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic h);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(posedge sys_clk);
      d = reg_rdata;
      h = reg_hit;
   endtask
endmodule

// file: testbench/test_lcc_config_regs.sv
// Self-checking testbench for the lane conditioning register bank
`timescale 1ns/1ps
module test_lcc_config_regs import lcc_pkg::*;;
   logic                     sys_clk;
   logic                     rst_b;
   logic                     clk_en;
   logic                     reg_wr, reg_rd, reg_hit, rh;
   logic [7:0]               reg_addr, reg_wdata, reg_rdata, rv;
   lcc_out_ctl_t [N_OUT-1:0] out_ctl;
   lcc_in_ctl_t [N_IN-1:0]   in_ctl;
   int                       n_mismatch = 0;
   int                       checked = 0;
   lcc_config_regs dut (.sys_clk, .rst_b, .clk_en, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .out_ctl, .in_ctl);
   lcc_host_model host (.sys_clk, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_hit);
   // 25 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Write, then let the decoded controls settle
   task automatic wrs(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      @(posedge sys_clk);
      #1;
   endtask
   task automatic t_reset();
      logic [7:0] ad [12] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2B,
                              8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h32, 8'h34};
      logic [7:0] ex [12] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00, 8'h00,
                              8'h20, 8'h03, 8'h03, 8'h00, 8'h00, 8'h03};
      for (int i = 0; i < 12; i++) begin
         host.rd(ad[i], rv, rh);
         chk(rv, ex[i]);
         chk(8'(rh), 8'h01);
      end
      chk(8'(in_ctl[0].eq_step), 8'h00);
      chk(8'(out_ctl[2].swing_lvl), 8'h00);
      chk(8'({in_ctl[1].thr_deassert, in_ctl[1].thr_assert}), 8'h00);
   endtask
   // Every register keeps its own write; lanes decode what was stored
   task automatic t_readback();
      logic [7:0] ra [12] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2B,
                              8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h32, 8'h34};
      logic [7:0] wv [12] = '{8'h31, 8'h2A, 8'h07, 8'hE8, 8'h06, 8'h12,
                              8'h3D, 8'h0F, 8'h88, 8'h09, 8'h11, 8'h1F};
      for (int i = 0; i < 12; i++)
         host.wr(ra[i], wv[i]);
      for (int i = 0; i < 12; i++) begin
         host.rd(ra[i], rv, rh);
         chk(rv, wv[i]);
         chk(8'(rh), 8'h01);
      end
      chk(8'(out_ctl[0].de_step), 8'h01);
      chk(8'(out_ctl[1].swing_lvl), 8'h02);
      chk(8'(out_ctl[2].swing_lvl), 8'h03);
      chk(8'(in_ctl[1].eq_step), 8'h08);
      chk(8'(in_ctl[0].eq_step), 8'h01);
      chk(8'({in_ctl[0].thr_deassert, in_ctl[0].thr_assert}), 8'h06);
      chk(8'(out_ctl[0].mute), 8'h00);
      chk(8'(out_ctl[2].mute), 8'h01);
   endtask
   task automatic t_idle();
      logic [7:0] ad [3] = '{8'h23, 8'h2B, 8'h32};
      logic [7:0] d;
      for (int i = 0; i < 3; i++)
         for (int j = 0; j < 4; j++) begin
            d = {2'b00, j[1:0], 2'b00, j[1:0]};
            wrs(ad[i], d);
            rv = {6'h00, out_ctl[i].idle_auto, out_ctl[i].sig_det_en};
            chk(rv, {6'h00, d[5], d[5]});
            chk(8'(out_ctl[i].mute), 8'(!d[5] && d[4]));
            rv = {6'h00, out_ctl[i].rate_auto, out_ctl[i].rate};
            chk(rv, {6'h00, d[1:0]});
         end
   endtask
   task automatic t_eq();
      logic [7:0] c [9] = '{8'h20, 8'h2A, 8'h30, 8'h32, 8'h39, 8'h35,
                            8'h37, 8'h3B, 8'h3D};
      for (int k = 0; k < 9; k++) begin
         wrs(8'h24, c[k]);
         chk(8'(in_ctl[0].eq_step), 8'(k));
         chk(8'(in_ctl[0][13:8]), c[k]);
         wrs(8'h2C, c[k]);
         chk(8'(in_ctl[1].eq_step), 8'(k));
      end
      wrs(8'h24, 8'h21);
      chk(8'(in_ctl[0].eq_step), 8'h0F);
   endtask
   task automatic t_swing_de();
      logic [7:0] s [4] = '{8'h03, 8'h07, 8'h0F, 8'h1F};
      logic [7:0] e [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
      for (int k = 0; k < 4; k++) begin
         wrs(8'h25, s[k]);
         chk(8'(out_ctl[0].swing_lvl), 8'(k));
      end
      wrs(8'h25, 8'h3F);
      host.rd(8'h25, rv, rh);
      chk(rv, 8'h1F);
      wrs(8'h25, 8'h05);
      chk(8'(out_ctl[0].swing_lvl), 8'h07);
      for (int k = 0; k < 5; k++) begin
         wrs(8'h2E, e[k]);
         chk(8'(out_ctl[1].de_step), 8'(k));
         chk({out_ctl[1].de_type, out_ctl[1].de_level}, e[k]);
      end
   endtask
   task automatic t_thr_misc();
      logic [7:0] d;
      for (int k = 0; k < 4; k++) begin
         d = {4'h0, k[1:0], ~k[1:0]};
         wrs(8'h2F, d);
         chk(8'({in_ctl[1].thr_deassert, in_ctl[1].thr_assert}), d);
      end
      wrs(8'h28, 8'h55);
      host.rd(8'h28, rv, rh);
      chk(rv, 8'h00);
      chk(8'(rh), 8'h00);
      #1;
      clk_en = 1'b0;
      host.wr(8'h2F, 8'h05);
      clk_en = 1'b1;
      host.rd(8'h2F, rv, rh);
      chk(rv, 8'h0C);
   endtask
   // Main sequence
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      repeat (16) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      t_reset();
      t_readback();
      t_idle();
      t_eq();
      t_swing_de();
      t_thr_misc();
      finish_test();
   end
   // Hang guard
   initial begin
      #1000000;
      n_mismatch++;
      finish_test();
   end
endmodule
